// ### uers_axil.sv
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ps
module uers_axil (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             wr_take,
    output logic [31:0]      wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_ok,
    output logic             rd_take,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);

    // ------------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------------
    wire aw_hs = awvalid && awready;
    wire w_hs  = wvalid && wready;
    wire b_hs  = bvalid && bready;
    wire r_hs  = rvalid && rready;

    // Both halves held and no answer pending
    assign wr_take = !awready && !wready && !bvalid;
    assign rd_take = arvalid && arready;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= uers_pkg::RESP_OKAY;
            wr_addr <= uers_pkg::WORD_ZERO;
            wr_data <= uers_pkg::WORD_ZERO;
            wr_strb <= 4'h0;
        end else begin
            if (aw_hs) begin
                awready <= 1'b0;
                wr_addr <= awaddr;
            end
            if (w_hs) begin
                wready  <= 1'b0;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_take) begin
                bvalid <= 1'b1;
                bresp  <= wr_ok ? uers_pkg::RESP_OKAY : uers_pkg::RESP_SLVERR;
            end else if (b_hs) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= uers_pkg::WORD_ZERO;
            rresp   <= uers_pkg::RESP_OKAY;
        end else if (rd_take) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_ok ? rd_data : uers_pkg::WORD_ZERO;
            rresp   <= rd_ok ? uers_pkg::RESP_OKAY : uers_pkg::RESP_SLVERR;
        end else if (r_hs) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

endmodule

// ### uers_host_model.sv
// Behavioural USB engine side: one-cycle endpoint events
`timescale 1ns/1ps
module uers_host_model #(
    parameter int NUM_EP = 6
) (
    input  logic                                  clock,
    output uers_pkg::uers_usb_ev_t [NUM_EP-1:0]   usb_ev,
    input  uers_pkg::uers_ep_state_t [NUM_EP-1:0] ep_state
);
    initial usb_ev = '0;

    // Mask order: ack, bank0, bank1, setup, stall, crc, sent, toggle
    task pulse(input int ep, input logic [7:0] m, input logic [10:0] c);
        @(posedge clock);
        usb_ev[ep] <= uers_pkg::uers_usb_ev_t'({m, c});
        @(posedge clock);
        // Count carries the inverted value outside a pulse
        usb_ev[ep] <= uers_pkg::uers_usb_ev_t'({8'h00, ~c});
    endtask

    task in_xfer(input int ep);
        for (int n = 0; n < 100 && !ep_state[ep].transmit_ready; n++) begin
            @(posedge clock);
        end
        pulse(ep, 8'h02, 11'h000);
        pulse(ep, 8'h80, 11'h000);
    endtask
endmodule

// ### uers_pkg.sv
// Register map, field layout and carrier types of the endpoint reset/status block
package uers_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_ENDPOINT_FIFO_RESET      = 32'hfffa4028;
    localparam logic [31:0] ADDR_ENDPOINT_CONTROL_STATUS  = 32'hfffa402c;
    localparam logic [31:0] ADDR_STRIDE                   = 32'h00000004;

    // ------------------------------------------------------------------
    // Control/status field positions
    // ------------------------------------------------------------------
    localparam int BIT_TRANSMIT_COMPLETE = 0;
    localparam int BIT_RECEIVE_BANK0     = 1;
    localparam int BIT_SETUP_RECEIVED    = 2;
    localparam int BIT_STALL_ACK         = 3;
    localparam int BIT_TRANSMIT_READY    = 4;
    localparam int BIT_FORCE_STALL       = 5;
    localparam int BIT_RECEIVE_BANK1     = 6;
    localparam int BIT_DIRECTION         = 7;
    localparam int BIT_KIND_LSB          = 8;
    localparam int BIT_DATA_TOGGLE       = 11;
    localparam int BIT_ENABLE            = 15;
    localparam int BIT_COUNT_LSB         = 16;
    localparam int KIND_W                = 3;
    localparam int COUNT_W               = 11;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [KIND_W-1:0]  KIND_CONTROL   = 3'h0;
    localparam logic [1:0]         KIND_ISO_LOW   = 2'h1;
    localparam logic [COUNT_W-1:0] COUNT_RESET    = 11'h000;
    localparam logic [1:0]         RESP_OKAY      = 2'h0;
    localparam logic [1:0]         RESP_SLVERR    = 2'h2;
    localparam logic [31:0]        WORD_ZERO      = 32'h00000000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // Per-endpoint events from the USB protocol engine, one-cycle pulses
    typedef struct packed {
        logic               in_acked;
        logic               rx_bank0;
        logic               rx_bank1;
        logic               setup_rx;
        logic               stall_acked;
        logic               crc_error;
        logic               tx_sent;
        logic               toggle_flip;
        logic [COUNT_W-1:0] rx_count;
    } uers_usb_ev_t;

    // Per-endpoint state back to the USB protocol engine
    typedef struct packed {
        logic              transmit_ready;
        logic              refuse_data_out;
        logic              data_toggle;
        logic              fifo_reset;
        logic              bank0_full;
        logic              bank1_full;
        logic              force_stall;
        logic              enable;
        logic              direction;
        logic [KIND_W-1:0] kind;
    } uers_ep_state_t;

endpackage

// ### uers_top.sv
// Endpoint reset and control/status flags of a full-speed USB device port
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps

// What this block does
// - Endpoint reset bit clears that endpoint's FIFO and received byte count.
// - Endpoint reset bit returns the data toggle to DATA0.
// - While reset bit is 1, FIFO pointers and byte count stay zero; flags untouched.
// - Host IN acknowledge sets transmit-complete; writing 0 clears, 1 does nothing.
// - Packet stored in bank 0 sets bank-0 flag; writing 1 leaves it.
// - Valid setup packet sets setup flag; writing 0 clears, 1 does nothing.
// - While setup flag is set, following Data OUT transactions are refused.
// - Acknowledged STALL sets stall flag on non-isochronous endpoints; write 0 clears.
// - On isochronous endpoints the same flag reports a CRC error.
// - Endpoint interrupt status stays set until every causing flag is cleared.
// - Firmware sets transmit-ready after loading data; device clears it once sent.
module uers_top #(
    parameter int NUM_EP = 6
) (
    input  wire logic                                clock,
    input  wire logic                                sys_rst,
    input  wire logic [31:0]                         awaddr,
    input  wire logic                                awvalid,
    output logic                                     awready,
    input  wire logic [31:0]                         wdata,
    input  wire logic [3:0]                          wstrb,
    input  wire logic                                wvalid,
    output logic                                     wready,
    output logic [1:0]                               bresp,
    output logic                                     bvalid,
    input  wire logic                                bready,
    input  wire logic [31:0]                         araddr,
    input  wire logic                                arvalid,
    output logic                                     arready,
    output logic [31:0]                              rdata,
    output logic [1:0]                               rresp,
    output logic                                     rvalid,
    input  wire logic                                rready,
    input  wire uers_pkg::uers_usb_ev_t [NUM_EP-1:0] usb_ev,
    output uers_pkg::uers_ep_state_t [NUM_EP-1:0]    ep_state,
    output logic [NUM_EP-1:0]                        endpoint0_interrupt_status
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte-lane merge of a write onto the current word
    function automatic logic [31:0] lane_merge(
        input logic [31:0] cur,
        input logic [31:0] nw,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = cur;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Flag that hardware sets and a write clears; the set wins
    function automatic logic sticky(
        input logic cur,
        input logic set,
        input logic clr
    );
        return set | (cur & ~clr);
    endfunction

    // Byte address of one endpoint's control/status word
    function automatic logic [31:0] csr_addr(input int idx);
        return uers_pkg::ADDR_ENDPOINT_CONTROL_STATUS
             + uers_pkg::ADDR_STRIDE * 32'(idx);
    endfunction

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    logic        wr_take;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic        rd_take;
    logic [31:0] rd_data;
    logic        rd_ok;

    uers_axil u_axil (
        .clock   (clock),
        .sys_rst (sys_rst),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_take (wr_take),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (wr_ok),
        .rd_take (rd_take),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [NUM_EP-1:0] ep_reset;
    logic [NUM_EP-1:0] csr_wr_hit;
    logic [NUM_EP-1:0] csr_rd_hit;
    logic [31:0]       csr_word [NUM_EP];

    wire rst_wr_hit = (wr_addr == uers_pkg::ADDR_ENDPOINT_FIFO_RESET);
    wire rst_rd_hit = (araddr == uers_pkg::ADDR_ENDPOINT_FIFO_RESET);
    wire [31:0] rst_word = {{(32 - NUM_EP){1'b0}}, ep_reset};
    wire [31:0] rst_merged = lane_merge(rst_word, wr_data, wr_strb);

    assign wr_ok = rst_wr_hit || (|csr_wr_hit);
    assign rd_ok = rst_rd_hit || (|csr_rd_hit);

    always_comb begin
        rd_data = rst_rd_hit ? rst_word : uers_pkg::WORD_ZERO;
        for (int i = 0; i < NUM_EP; i++) begin
            if (csr_rd_hit[i]) begin
                rd_data = csr_word[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Endpoint reset register
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ep_reset <= '0;
        end else if (wr_take && rst_wr_hit) begin
            ep_reset <= rst_merged[NUM_EP-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Per-endpoint flags
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
        logic                          transmit_complete_flag;
        logic                          bank0;
        logic                          bank1;
        logic                          setup;
        logic                          stall;
        logic                          txrdy;
        logic                          fstall;
        logic                          dir;
        logic                          toggle;
        logic                          enable;
        logic                          fifo_rst;
        logic                          irq;
        logic [uers_pkg::KIND_W-1:0]   kind;
        logic [uers_pkg::COUNT_W-1:0]  count;
        logic                          next_transmit_complete_flag;
        logic                          next_bank0;
        logic                          next_bank1;
        logic                          next_setup;
        logic                          next_stall;
        logic                          next_txrdy;

        wire        hit = wr_take && csr_wr_hit[g];
        wire [31:0] wd  = lane_merge(csr_word[g], wr_data, wr_strb);
        wire        iso = (kind[1:0] == uers_pkg::KIND_ISO_LOW);
        wire        is_ctrl = (kind == uers_pkg::KIND_CONTROL);
        wire        rx_any = ((usb_ev[g].rx_bank0 | usb_ev[g].rx_bank1) & ~setup)
                           | usb_ev[g].setup_rx;

        assign csr_wr_hit[g] = (wr_addr == csr_addr(g));
        assign csr_rd_hit[g] = (araddr == csr_addr(g));

        assign csr_word[g] = {
            5'h00,
            count,
            is_ctrl | enable,
            3'h0,
            toggle,
            kind,
            dir,
            bank1,
            fstall,
            txrdy,
            stall,
            setup,
            bank0,
            transmit_complete_flag
        };

        // IN ack sets, write 0 clears
        assign next_transmit_complete_flag = sticky(transmit_complete_flag, usb_ev[g].in_acked,
                                    hit && !wd[uers_pkg::BIT_TRANSMIT_COMPLETE]);
        // bank 0 filled, write 1 keeps
        assign next_bank0 = sticky(bank0, usb_ev[g].rx_bank0 && !setup,
                                   hit && !wd[uers_pkg::BIT_RECEIVE_BANK0]);
        assign next_bank1 = sticky(bank1, usb_ev[g].rx_bank1 && !setup,
                                   hit && !wd[uers_pkg::BIT_RECEIVE_BANK1]);
        assign next_setup = sticky(setup, usb_ev[g].setup_rx,
                                   hit && !wd[uers_pkg::BIT_SETUP_RECEIVED]);
        assign next_stall = sticky(stall,
                                   iso ? usb_ev[g].crc_error : usb_ev[g].stall_acked,
                                   hit && !wd[uers_pkg::BIT_STALL_ACK]);
        assign next_txrdy = sticky(txrdy, hit && wd[uers_pkg::BIT_TRANSMIT_READY],
                                   usb_ev[g].tx_sent
                                   || (hit && !wd[uers_pkg::BIT_TRANSMIT_READY]));

        always_ff @(posedge clock) begin
            if (sys_rst) begin
                transmit_complete_flag <= 1'b0;
                bank0  <= 1'b0;
                bank1  <= 1'b0;
                setup  <= 1'b0;
                stall  <= 1'b0;
                txrdy  <= 1'b0;
                irq    <= 1'b0;
            end else begin
                transmit_complete_flag <= next_transmit_complete_flag;
                bank0  <= next_bank0;
                bank1  <= next_bank1;
                setup  <= next_setup;
                stall  <= next_stall;
                txrdy  <= next_txrdy;
                irq    <= next_transmit_complete_flag | next_bank0 | next_bank1
                        | next_setup | next_stall;
            end
        end

        // Configuration fields
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                fstall <= 1'b0;
                dir    <= 1'b0;
                enable <= 1'b0;
                kind   <= uers_pkg::KIND_CONTROL;
            end else if (hit) begin
                fstall <= wd[uers_pkg::BIT_FORCE_STALL];
                dir    <= wd[uers_pkg::BIT_DIRECTION];
                enable <= wd[uers_pkg::BIT_ENABLE];
                kind   <= wd[uers_pkg::BIT_KIND_LSB +: uers_pkg::KIND_W];
            end
        end

        // Toggle, byte count and FIFO pointer reset
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                toggle   <= 1'b0;
                count    <= uers_pkg::COUNT_RESET;
                fifo_rst <= 1'b0;
            end else begin
                fifo_rst <= ep_reset[g];
                if (ep_reset[g]) begin
                    count <= uers_pkg::COUNT_RESET;
                end else if (rx_any) begin
                    count <= usb_ev[g].rx_count;
                end
                if (ep_reset[g]) begin
                    toggle <= 1'b0;
                end else if (usb_ev[g].toggle_flip) begin
                    toggle <= ~toggle;
                end
            end
        end

        assign ep_state[g].refuse_data_out = setup;
        assign ep_state[g].transmit_ready  = txrdy;
        assign ep_state[g].data_toggle     = toggle;
        assign ep_state[g].fifo_reset      = fifo_rst;
        assign ep_state[g].bank0_full      = bank0;
        assign ep_state[g].bank1_full      = bank1;
        assign ep_state[g].force_stall     = fstall;
        assign ep_state[g].enable          = enable;
        assign ep_state[g].direction       = dir;
        assign ep_state[g].kind            = kind;
        assign endpoint0_interrupt_status[g] = irq;
    end

endmodule

// ### uers_top_assertions.sv
// Port-level concurrent checks of the endpoint reset/status block
`timescale 1ns/1ps
module uers_top_chk #(
    parameter int NUM_EP = 6
) (
    input logic                                  clock,
    input logic                                  sys_rst,
    input logic                                  awvalid,
    input logic                                  awready,
    input logic                                  wvalid,
    input logic                                  wready,
    input logic                                  bvalid,
    input logic                                  bready,
    input logic                                  arvalid,
    input logic                                  arready,
    input logic                                  rvalid,
    input logic                                  rready,
    input uers_pkg::uers_usb_ev_t [NUM_EP-1:0]   usb_ev,
    input uers_pkg::uers_ep_state_t [NUM_EP-1:0] ep_state,
    input logic [NUM_EP-1:0]                     endpoint0_interrupt_status
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    sequence both_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence resp_after;
        !bvalid ##1 bvalid;
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    refuse_set_a : assert property (usb_ev[0].setup_rx |=> ep_state[0].refuse_data_out)
        else $error("refusal not raised");
    bank_refuse_a : assert property (ep_state[0].refuse_data_out && usb_ev[0].rx_bank0
        && !ep_state[0].bank0_full |=> !ep_state[0].bank0_full)
        else $error("bank 0 filled during setup");
    transmit_complete_flag_int_a : assert property (usb_ev[1].in_acked |=> endpoint0_interrupt_status[1])
        else $error("no interrupt on IN ack");
    sticky_int_a : assert property (|(~endpoint0_interrupt_status
        & $past(endpoint0_interrupt_status)) |-> $rose(bvalid))
        else $error("interrupt dropped early");
    stall_iso_a : assert property ((ep_state[4].kind[1:0] == 2'h1 ? usb_ev[4].crc_error
        : usb_ev[4].stall_acked) |=> endpoint0_interrupt_status[4])
        else $error("no stall interrupt");
    txrdy_clear_a : assert property (usb_ev[1].tx_sent
        |=> !ep_state[1].transmit_ready || $rose(bvalid))
        else $error("ready kept after send");
    toggle_reset_a : assert property ($rose(ep_state[3].fifo_reset)
        |-> !ep_state[3].data_toggle)
        else $error("toggle not DATA0");
    wr_resp_a : assert property (both_taken |=> resp_after)
        else $error("write response timing");
    rd_resp_a : assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read data timing");
    b_release_a : assert property (bvalid && bready |=> !bvalid && awready && wready)
        else $error("write channel not freed");
endmodule

bind uers_top uers_top_chk #(.NUM_EP(NUM_EP)) chk (.clock, .sys_rst, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .usb_ev,
    .ep_state, .endpoint0_interrupt_status);

// ### uers_top_tb.sv
// Self-checking bench for the endpoint reset/status block
`timescale 1ns/1ps
module uers_top_tb;
    localparam logic [31:0] KEEP = 32'h0000004e;
    localparam logic [31:0] RST  = uers_pkg::ADDR_ENDPOINT_FIFO_RESET;
    localparam logic [1:0]  OK   = uers_pkg::RESP_OKAY;
    logic clock, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [5:0] endpoint0_interrupt_status;
    uers_pkg::uers_usb_ev_t [5:0] usb_ev;
    uers_pkg::uers_ep_state_t [5:0] ep_state;
    int n_mismatch, comparisons, cycles;

    uers_top #(.NUM_EP(6)) dut (.clock, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .usb_ev, .ep_state, .endpoint0_interrupt_status);
    uers_host_model #(.NUM_EP(6)) host (.clock, .usb_ev, .ep_state);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] csr(input int ep);
        return uers_pkg::ADDR_ENDPOINT_CONTROL_STATUS + uers_pkg::ADDR_STRIDE * 32'(ep);
    endfunction

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        check("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask

    task automatic csr_chk(input int ep, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] d;
        rd(csr(ep), d, OK);
        check("csr", d & m, exp);
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] d, k;
        logic [7:0]  good;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr} = '0;
        wstrb = 4'hf;
        sys_rst = 1'b1;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        for (int e = 0; e < 6; e++) csr_chk(e, 32'hffffffff, 32'h00008000);
        rd(RST, d, OK);
        check("reset reg", d, 32'h0);
        rd(32'hfffa4044, d, uers_pkg::RESP_SLVERR);
        check("unmapped", d, 32'h0);
        wr(32'hfffa4044, 32'h1, uers_pkg::RESP_SLVERR);
        $display("done reset");
        wr(csr(1), KEEP | 32'h10, OK);
        csr_chk(1, 32'h1f, 32'h10);
        host.in_xfer(1);
        csr_chk(1, 32'h1f, 32'h01);
        check("int", 32'(endpoint0_interrupt_status[1]), 32'h1);
        wr(csr(1), KEEP | 32'h1, OK);
        csr_chk(1, 32'h1, 32'h1);
        wr(csr(1), KEEP, OK);
        csr_chk(1, 32'h1, 32'h0);
        check("int", 32'(endpoint0_interrupt_status[1]), 32'h0);
        $display("done transmit");
        host.pulse(2, 8'h40, 11'h040);
        csr_chk(2, 32'h07ff0002, 32'h00400002);
        wr(csr(2), KEEP, OK);
        csr_chk(2, 32'h2, 32'h2);
        wr(RST, 32'h4, OK);
        csr_chk(2, 32'h07ff0002, 32'h00000002);
        check("fifo", 32'(ep_state[2].fifo_reset), 32'h1);
        wr(RST, 32'h0, OK);
        csr_chk(2, 32'h07ff0000, 32'h0);
        wr(csr(2), KEEP & ~32'h2, OK);
        repeat (8) @(posedge clock);
        csr_chk(2, 32'h2, 32'h0);
        $display("done bank0");
        host.pulse(3, 8'h01, 11'h000);
        csr_chk(3, 32'h800, 32'h800);
        wr(RST, 32'h8, OK);
        wr(RST, 32'h0, OK);
        csr_chk(3, 32'h800, 32'h0);
        $display("done toggle");
        host.pulse(0, 8'h10, 11'h008);
        wr(csr(0), KEEP, OK);
        host.pulse(0, 8'h40, 11'h020);
        csr_chk(0, 32'h07ff0006, 32'h00080004);
        check("refuse", 32'(ep_state[0].refuse_data_out), 32'h1);
        wr(csr(0), KEEP & ~32'h4, OK);
        csr_chk(0, 32'h4, 32'h0);
        $display("done setup");
        for (int i = 0; i < 2; i++) begin
            k = i ? 32'h100 : 32'h200;
            good = i ? 8'h04 : 8'h08;
            wr(csr(4), KEEP | k, OK);
            host.pulse(4, good ^ 8'h0c, 11'h000);
            csr_chk(4, 32'h8, 32'h0);
            host.pulse(4, good, 11'h000);
            csr_chk(4, 32'h8, 32'h8);
            wr(csr(4), (KEEP & ~32'h8) | k, OK);
            csr_chk(4, 32'h708, k);
        end
        $display("done stall");
        host.pulse(5, 8'h80, 11'h000);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        csr_chk(5, 32'hffffffff, 32'h00008000);
        $display("done mid-run reset");
        close_out();
    end
endmodule
